// >>> core/gtc_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defs.vh"

// Overview of operation
// - Off when on bit clear; free-running, or gated when gate enable set.
// - Sixteen-bit up counter; writing either byte replaces that byte at once.
// - Source: 00 instruction clock, 01 system clock, 10 oscillator or pin, 11 reserved.
// - System clock source advances four counts per instruction cycle, then prescaled.
// - External source counts rising edges, synchronised or asynchronous.
// - Counter mode needs a falling edge first after enable, write or disable.
// - Prescale field divides the selected clock by 1, 2, 4 or 8.
// - Prescaler hidden from software; cleared by any count byte write.
// - Oscillator enable starts the low-power oscillator; it keeps running in sleep.
// - Unsynchronised external clock keeps counting in sleep and can wake on overflow.
// - Sync to async switch may lose one count; reverse may add one.
// - Count byte reads during asynchronous counting always return a valid value.
// - With gating, count on clock rising edges only while gate active; else hold.
// - Polarity bit: gate active low when 0, active high when 1.
// - Gate source: 00 pin, 01 eight-bit timer overflow, 10 comparator 1, 11 comparator 2.
// - Eight-bit timer wrap FFh to 00h gives a gate pulse.
// - Comparator gate inputs used synchronised to counter clock or unsynchronised.
// - Toggle mode passes gate through a flip-flop toggling on each rising edge of the polarity-adjusted gate.
// - Toggle flip-flop forced and held at zero while toggle bit clear.
// - Wrap FFFFh to 0000h sets the overflow flag; only software clears it.
// - Clearing the on bit stops counting and clears the gate flip-flop.
module gtc_timer (
   input wire aclk,
   input wire aresetn,
   input wire [`GTC_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`GTC_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire external_clock_pin,
   input wire oscillator_input_pin,
   output wire oscillator_output_pin,
   input wire gate_input_pin,
   input wire comparator_one_output,
   input wire comparator_two_output,
   input wire comp1_sync_en,
   input wire comp2_sync_en,
   input wire [7:0] eight_bit_timer_count,
   input wire sleep_mode,
   output wire overflow_flag,
   output wire wake_request
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   reg awready_r;
   reg wready_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg arready_r;
   reg rvalid_r;
   reg [1:0] rresp_r;
   reg [31:0] rdata_r;
   reg [`GTC_ADDR_W-1:0] waddr_r;
   reg [7:0] wbyte_r;
   reg wen_r;
   reg wstb_r;
   reg [7:0] ctrl_r;
   reg [7:0] gate_r;
   reg [15:0] count_r;
   reg [15:0] count_nxt;
   reg [2:0] presc_r;
   reg [1:0] phase_r;
   reg ovf_r;
   reg wake_r;
   reg osc_out_r;
   reg ext_rs_r;
   reg ext_prev_r;
   reg armed_r;
   reg on_prev_r;
   reg [7:0] t8_prev_r;
   reg c1_lat_r;
   reg c2_lat_r;
   reg gsrc_prev_r;
   reg tff_r;
   reg gval_r;
   wire [4:0] pin_s;
   wire ext_s;
   wire osc_s;
   wire gpin_s;
   wire c1_s;
   wire c2_s;
   wire on_bit;
   wire ge_bit;
   wire pol_bit;
   wire tm_bit;
   wire sync_dis;
   wire osc_en;
   wire [1:0] cs_f;
   wire [1:0] ps_f;
   wire [1:0] gss_f;
   wire ext_mode;
   wire ext_raw;
   wire ext_lvl;
   wire ext_rise;
   wire ext_fall;
   reg src_tick;
   wire [2:0] presc_lim;
   wire pre_tick;
   wire t8_wrap;
   reg gsrc_raw;
   wire gsrc_act;
   wire gate_val;
   wire count_en;
   wire inc;
   wire cnt_wr;
   wire wr_go;
   wire rd_go;

   // ------------------------------------------------------------
   // Address decode shared by read and write paths
   // ------------------------------------------------------------
   function mapped;
      input [`GTC_ADDR_W-1:0] a;
      begin
         mapped = (a == `GTC_OFS_CTRL) || (a == `GTC_OFS_GATE) ||
            (a == `GTC_OFS_CNT_LO) || (a == `GTC_OFS_CNT_HI) ||
            (a == `GTC_OFS_STATUS);
      end
   endfunction

   // ------------------------------------------------------------
   // Field views
   // ------------------------------------------------------------
   assign on_bit = ctrl_r[`GTC_CTRL_ON];
   assign sync_dis = ctrl_r[`GTC_CTRL_SYNC_DIS];
   assign osc_en = ctrl_r[`GTC_CTRL_OSC_EN];
   assign ps_f = ctrl_r[`GTC_CTRL_PS_LSB+1:`GTC_CTRL_PS_LSB];
   assign cs_f = ctrl_r[`GTC_CTRL_CS_LSB+1:`GTC_CTRL_CS_LSB];
   assign ge_bit = gate_r[`GTC_GATE_GE];
   assign pol_bit = gate_r[`GTC_GATE_POL];
   assign tm_bit = gate_r[`GTC_GATE_TM];
   assign gss_f = gate_r[`GTC_GATE_GSS_LSB+1:`GTC_GATE_GSS_LSB];

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // two-flop sync
   gtc_sync #(
      .W(5)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({comparator_two_output, comparator_one_output, gate_input_pin,
         oscillator_input_pin, external_clock_pin}),
      .q(pin_s)
   );
   assign ext_s = pin_s[0];
   assign osc_s = pin_s[1];
   assign gpin_s = pin_s[2];
   assign c1_s = pin_s[3];
   assign c2_s = pin_s[4];

   // ------------------------------------------------------------
   // External clock path
   // ------------------------------------------------------------
   assign ext_mode = (cs_f == `GTC_CS_EXT);
   assign ext_raw = osc_en ? osc_s : ext_s;
   // Sync mode adds a system-clock alignment stage, so a mode switch can drop or add one edge
   // sync or async
   assign ext_lvl = sync_dis ? ext_raw : ext_rs_r;
   assign ext_rise = ext_lvl & ~ext_prev_r;
   assign ext_fall = ~ext_lvl & ext_prev_r;

   // ------------------------------------------------------------
   // Source tick selection
   // ------------------------------------------------------------
   // Fosc halts in sleep; only the unsynchronised external path keeps ticking
   always @* begin
      case (cs_f)
         `GTC_CS_INSN: src_tick = ~sleep_mode &
            (phase_r == (`GTC_INSN_DIV - 1));
         `GTC_CS_SYS: src_tick = ~sleep_mode;
         `GTC_CS_EXT: src_tick = ext_rise & armed_r & (sync_dis | ~sleep_mode);
         default: src_tick = 1'b0;
      endcase
   end

   assign presc_lim = (3'h1 << ps_f) - 3'h1;
   // Catch up at once if the prescale field shrank under a running count
   assign pre_tick = src_tick & (presc_r >= presc_lim);

   // ------------------------------------------------------------
   // Gate path
   // ------------------------------------------------------------
   // wrap pulse
   assign t8_wrap = (t8_prev_r == `GTC_T8_MAX) &&
      (eight_bit_timer_count == `GTC_T8_ZERO);

   always @* begin
      case (gss_f)
         `GTC_GSS_PIN: gsrc_raw = gpin_s;
         `GTC_GSS_T8: gsrc_raw = t8_wrap;
         `GTC_GSS_C1: gsrc_raw = comp1_sync_en ? c1_lat_r : c1_s;
         `GTC_GSS_C2: gsrc_raw = comp2_sync_en ? c2_lat_r : c2_s;
         default: gsrc_raw = 1'b0;
      endcase
   end

   assign gsrc_act = pol_bit ? gsrc_raw : ~gsrc_raw;
   assign gate_val = tm_bit ? tff_r : gsrc_act;
   assign count_en = on_bit & (~ge_bit | gate_val);
   assign inc = count_en & pre_tick;

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   assign wr_go = ~awready_r & ~wready_r & ~bvalid_r;
   assign rd_go = s_axi_arvalid & arready_r;
   assign cnt_wr = wen_r &&
      ((waddr_r == `GTC_OFS_CNT_LO) || (waddr_r == `GTC_OFS_CNT_HI));

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= `GTC_RESP_OKAY;
         waddr_r <= {`GTC_ADDR_W{1'b0}};
         wbyte_r <= 8'h00;
         wen_r <= 1'b0;
         wstb_r <= 1'b0;
      end else begin
         // Write lands only once both beats are in, whichever came first
         wen_r <= ((s_axi_awvalid && awready_r) || !awready_r) &&
            ((s_axi_wvalid && wready_r) || !wready_r) && (awready_r || wready_r) &&
            (wready_r ? s_axi_wstrb[0] : wstb_r);
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wbyte_r <= s_axi_wdata[7:0];
            wstb_r <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= mapped(waddr_r) ? `GTC_RESP_OKAY : `GTC_RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Register updates land the cycle after the later of the address and data beats is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= `GTC_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else begin
         if (rd_go) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= mapped(s_axi_araddr) ? `GTC_RESP_OKAY : `GTC_RESP_SLVERR;
            case (s_axi_araddr)
               `GTC_OFS_CTRL: rdata_r <= {24'h000000, ctrl_r};
               `GTC_OFS_GATE: rdata_r <= {24'h000000, gate_r[7:3], gval_r,
                  gate_r[1:0]};
               `GTC_OFS_CNT_LO: rdata_r <= {24'h000000, count_r[7:0]};
               `GTC_OFS_CNT_HI: rdata_r <= {24'h000000, count_r[15:8]};
               `GTC_OFS_STATUS: rdata_r <= {31'h00000000, ovf_r};
               default: rdata_r <= 32'h00000000;
            endcase
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `GTC_CTRL_RST;
         gate_r <= `GTC_GATE_RST;
      end else if (wen_r) begin
         if (waddr_r == `GTC_OFS_CTRL)
            ctrl_r <= wbyte_r & `GTC_CTRL_MASK;
         if (waddr_r == `GTC_OFS_GATE)
            gate_r <= wbyte_r & `GTC_GATE_MASK;
      end
   end

   // ------------------------------------------------------------
   // Counter and prescaler
   // ------------------------------------------------------------
   always @* begin
      count_nxt = count_r;
      if (inc)
         count_nxt = count_r + 16'h0001;
      // A byte write wins over an increment in the same cycle
      // direct byte write
      if (wen_r && (waddr_r == `GTC_OFS_CNT_LO))
         count_nxt = {count_r[15:8], wbyte_r};
      if (wen_r && (waddr_r == `GTC_OFS_CNT_HI))
         count_nxt = {wbyte_r, count_r[7:0]};
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= `GTC_CNT_RST;
         presc_r <= 3'h0;
         phase_r <= 2'h0;
      end else begin
         count_r <= count_nxt;
         if (!sleep_mode)
            phase_r <= phase_r + 2'h1;
         if (cnt_wr)
            presc_r <= 3'h0;
         else if (count_en && src_tick)
            presc_r <= pre_tick ? 3'h0 : presc_r + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // Overflow flag and wake
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         ovf_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         if (inc && (count_r == `GTC_CNT_MAX) && !cnt_wr)
            ovf_r <= 1'b1;
         else if (wen_r && (waddr_r == `GTC_OFS_STATUS) && wbyte_r[`GTC_STAT_OVF])
            ovf_r <= 1'b0;
         wake_r <= sleep_mode & (ovf_r |
            (inc && (count_r == `GTC_CNT_MAX) && !cnt_wr));
      end
   end

   // ------------------------------------------------------------
   // External edge tracking and counter-mode arming
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         ext_rs_r <= 1'b0;
         ext_prev_r <= 1'b0;
         armed_r <= 1'b0;
         on_prev_r <= 1'b0;
      end else begin
         ext_rs_r <= ext_raw;
         ext_prev_r <= ext_lvl;
         on_prev_r <= on_bit;
         if (!on_bit || cnt_wr || !ext_mode || (on_bit && !on_prev_r))
            armed_r <= 1'b0;
         else if (ext_fall)
            armed_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Oscillator driver
   // ------------------------------------------------------------
   // Amplifier output inverts the crystal input; sleep does not stop it
   always @(posedge aclk) begin
      if (!aresetn)
         osc_out_r <= 1'b0;
      else
         osc_out_r <= osc_en & ~osc_s;
   end

   // ------------------------------------------------------------
   // Gate state
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         t8_prev_r <= 8'h00;
         c1_lat_r <= 1'b0;
         c2_lat_r <= 1'b0;
         gsrc_prev_r <= 1'b0;
         tff_r <= 1'b0;
         gval_r <= 1'b0;
      end else begin
         t8_prev_r <= eight_bit_timer_count;
         if (src_tick) begin
            c1_lat_r <= c1_s;
            c2_lat_r <= c2_s;
         end
         gsrc_prev_r <= gsrc_act;
         gval_r <= gate_val;
         if (!tm_bit || !on_bit)
            tff_r <= 1'b0;
         else if (gsrc_act && !gsrc_prev_r)
            tff_r <= ~tff_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign oscillator_output_pin = osc_out_r;
   assign overflow_flag = ovf_r;
   assign wake_request = wake_r;
endmodule // gtc_timer

`default_nettype wire

// >>> core/gtc_defs.vh
`ifndef GTC_DEFS_VH
`define GTC_DEFS_VH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define GTC_ADDR_W 5
`define GTC_OFS_CTRL 5'h00
`define GTC_OFS_GATE 5'h04
`define GTC_OFS_CNT_LO 5'h08
`define GTC_OFS_CNT_HI 5'h0C
`define GTC_OFS_STATUS 5'h10

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define GTC_CTRL_ON 0
`define GTC_CTRL_SYNC_DIS 2
`define GTC_CTRL_OSC_EN 3
`define GTC_CTRL_PS_LSB 4
`define GTC_CTRL_CS_LSB 6
`define GTC_CTRL_RST 8'h00
`define GTC_CTRL_MASK 8'hFD

// ---------------------------------------------------------------
// Gate register fields
// ---------------------------------------------------------------
`define GTC_GATE_GSS_LSB 0
`define GTC_GATE_VAL 2
`define GTC_GATE_TM 5
`define GTC_GATE_POL 6
`define GTC_GATE_GE 7
`define GTC_GATE_RST 8'h00
`define GTC_GATE_MASK 8'hE3

// ---------------------------------------------------------------
// Status register fields and count reset
// ---------------------------------------------------------------
`define GTC_STAT_OVF 0
`define GTC_CNT_RST 16'h0000
`define GTC_CNT_MAX 16'hFFFF

// ---------------------------------------------------------------
// Encodings
// ---------------------------------------------------------------
`define GTC_CS_INSN 2'h0
`define GTC_CS_SYS 2'h1
`define GTC_CS_EXT 2'h2
`define GTC_CS_RSVD 2'h3
`define GTC_GSS_PIN 2'h0
`define GTC_GSS_T8 2'h1
`define GTC_GSS_C1 2'h2
`define GTC_GSS_C2 2'h3
`define GTC_T8_MAX 8'hFF
`define GTC_T8_ZERO 8'h00
`define GTC_INSN_DIV 4
`define GTC_RESP_OKAY 2'h0
`define GTC_RESP_SLVERR 2'h2

`endif

// >>> core/gtc_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a bundle of independent pin levels
module gtc_sync #(
   parameter W = 5
) (
   input wire aclk,
   input wire aresetn,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   genvar i;

   // ------------------------------------------------------------
   // Per-bit stages
   // ------------------------------------------------------------
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge aclk) begin
            if (!aresetn) begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= d[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   assign q = sync_r;
endmodule // gtc_sync

`default_nettype wire

// >>> verif/gtc_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Bus and flag checks
// --------
module gtc_timer_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_mode,
   input wire logic overflow_flag,
   input wire logic wake_request
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
   chk_resp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   chk_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_byte_wide: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
   // Only a status write may clear the flag, and it lands as bvalid rises
   chk_flag_sticky: assert property (
      $fell(overflow_flag) |-> $rose(s_axi_bvalid)) else $error("flag cleared alone");
   chk_wake_cause: assert property (
      wake_request |-> $past(sleep_mode)) else $error("wake outside sleep");
   chk_wake_flag: assert property (
      $past(sleep_mode) && $past(overflow_flag) |-> wake_request) else $error("wake missing");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property ($rose(overflow_flag));
   cover property (wake_request);
endmodule // gtc_timer_sva
`default_nettype wire

// >>> verif/gtc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Pins and timer beyond the counter
// --------
module gtc_far_end (
   input wire logic aclk,
   output logic [4:0] ln,
   output logic [7:0] t8
);
   initial begin
      ln = 5'h00;
      t8 = 8'h00;
   end
   // one level change, held n cycles
   task flip(input int i, input int n);
      ln[i] <= ~ln[i];
      repeat (n) @(posedge aclk);
   endtask
   // slow clock, far above the two-flop limit
   task clocks(input int i, input int k);
      repeat (k) begin
         flip(i, 6);
         flip(i, 6);
      end
   endtask
   // eight-bit timer steps FFh to 00h
   task wrap(input int k);
      repeat (k) begin
         t8 <= 8'hFF;
         @(posedge aclk);
         t8 <= 8'h00;
         repeat (6) @(posedge aclk);
      end
   endtask
endmodule // gtc_far_end
`default_nettype wire

// >>> verif/gated_16bit_timer_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end
module gated_16bit_timer_counter_tb;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [4:0] awa = 5'h00, ara = 5'h00;
   logic awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
   logic slp = 1'h0, s1 = 1'h0, s2 = 1'h0;
   logic [7:0] wd = 8'h00, lo;
   logic [3:0] wst = 4'hF;
   logic [31:0] v;
   logic [1:0] r;
   wire awr, wrd, bv, arr, rv, oso, ovf, wake;
   wire [1:0] br, rr;
   wire [31:0] rdt;
   wire [4:0] ln;
   wire [7:0] t8;
   int errors = 0;
   int tests_run = 0;
   gtc_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata({24'h000000, wd}), .s_axi_wstrb(wst),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
      .external_clock_pin(ln[0]), .gate_input_pin(ln[1]), .comparator_one_output(ln[2]),
      .comparator_two_output(ln[3]), .oscillator_input_pin(ln[4]),
      .oscillator_output_pin(oso), .comp1_sync_en(s1), .comp2_sync_en(s2),
      .eight_bit_timer_count(t8), .sleep_mode(slp), .overflow_flag(ovf), .wake_request(wake));
   gtc_far_end far (.aclk(aclk), .ln(ln), .t8(t8));
   initial begin
      forever #25 aclk = ~aclk;
   end
   task close_out;
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge aclk);
      errors++;
      close_out;
   end
   // --------
   // Bus cycles
   // --------
   task wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'h0;
         if (wrd) wv <= 1'h0;
      end while (!bv);
      // Ready comes late on purpose so the answer must stand through a stall
      brd <= 1'h1;
      do @(posedge aclk); while (!bv);
      brd <= 1'h0;
      `CHK("bresp", e, br)
   endtask
   task rd(input logic [4:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'h1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'h0;
      end while (!rv);
      rrd <= 1'h1;
      do @(posedge aclk); while (!rv);
      rrd <= 1'h0;
      v = rdt;
      r = rr;
   endtask
   task rc(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
      rd(a);
      `CHK("register", {2'h0, e}, {r, v[7:0] & m})
   endtask
   task wc(input logic [7:0] d);
      wr(`GTC_OFS_CTRL, d, 2'h0);
   endtask
   task wg(input logic [7:0] d);
      wr(`GTC_OFS_GATE, d, 2'h0);
   endtask
   // counter is stopped or gated off here, so no write races an increment
   task setc(input logic [15:0] x);
      wr(`GTC_OFS_CNT_LO, x[7:0], 2'h0);
      wr(`GTC_OFS_CNT_HI, x[15:8], 2'h0);
   endtask
   task cnt(input logic [15:0] e);
      rd(`GTC_OFS_CNT_LO);
      lo = v[7:0];
      rd(`GTC_OFS_CNT_HI);
      `CHK("count", e, {v[7:0], lo})
   endtask
   // Both gate edges pass the same delay, so the window length is exact
   task win(input int i, input int n, input logic [7:0] ctl, input logic [15:0] e);
      setc(16'h0000);
      wc(ctl);
      repeat (8) @(posedge aclk);
      if (i == 5) begin
         far.wrap(n);
      end else begin
         far.flip(i, n);
         far.flip(i, 8);
      end
      wc(8'h00);
      cnt(e);
   endtask
   task arm;
      wc(8'h41);
      far.flip(1, 2);
      far.flip(1, 8);
   endtask
   // --------
   // Scenarios
   // --------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      for (int a = 0; a < 5; a++)
         rc(5'(a * 4), 8'h00, 8'hFB);
      rd(5'h14);
      `CHK("unmapped", {2'h2, 32'h00000000}, {r, v})
      wr(5'h14, 8'hFF, 2'h2);
      wst <= 4'hE;
      wc(8'h01);
      wst <= 4'hF;
      rc(`GTC_OFS_CTRL, 8'h00, 8'hFF);
      wc(8'hFD);
      rc(`GTC_OFS_CTRL, 8'hFD, 8'hFF);
      repeat (20) @(posedge aclk);
      cnt(16'h0000);
      wc(8'h00);
      wg(8'hC3);
      rc(`GTC_OFS_GATE, 8'hC3, 8'hE3);
      wg(8'hC0);
      for (int k = 0; k < 8; k++)
         win(1, 64, {1'h0, k[2], k[1:0], 4'h1}, (k[2] ? 16'h40 : 16'h10) >> k[1:0]);
      win(1, 64, 8'h40, 16'h0000);
      wg(8'hC2);
      s1 <= 1'h1;
      win(2, 64, 8'h41, 16'h0040);
      wg(8'hC3);
      win(3, 64, 8'h41, 16'h0040);
      wg(8'hC1);
      win(5, 3, 8'h41, 16'h0003);
      far.flip(1, 4);
      wg(8'h80);
      win(1, 64, 8'h41, 16'h0040);
      far.flip(1, 4);
      wg(8'hC0);
      // toggle enabled in a write of its own
      wg(8'hE0);
      setc(16'h0000);
      wc(8'h41);
      far.flip(1, 2);
      far.flip(1, 60);
      far.flip(1, 2);
      far.flip(1, 8);
      wc(8'h00);
      cnt(16'h003E);
      arm;
      wc(8'h00);
      win(4, 8, 8'h41, 16'h0000);
      arm;
      wg(8'hC0);
      wg(8'hE0);
      win(4, 8, 8'h41, 16'h0000);
      wg(8'h00);
      setc(16'h0000);
      wc(8'h81);
      far.clocks(0, 5);
      wc(8'h00);
      cnt(16'h0004);
      // start-up wait: preset FC00h, flag after 1024 cycles
      far.flip(4, 4);
      setc(16'hFC00);
      wc(8'h89);
      far.clocks(4, 1024);
      `CHK("overflow", 1'h1, ovf)
      wc(8'h88);
      cnt(16'h0000);
      far.flip(4, 6);
      `CHK("osc drive", 1'h1, oso)
      wr(`GTC_OFS_STATUS, 8'h01, 2'h0);
      rc(`GTC_OFS_STATUS, 8'h00, 8'h01);
      setc(16'hFFFE);
      wc(8'h85);
      slp <= 1'h1;
      far.clocks(0, 3);
      `CHK("wake", 2'h3, {ovf, wake})
      slp <= 1'h0;
      wc(8'h00);
      cnt(16'h0000);
      `CHK("wake", 1'h0, wake)
      setc(16'h0000);
      wc(8'h81);
      slp <= 1'h1;
      far.clocks(0, 3);
      slp <= 1'h0;
      wc(8'h00);
      cnt(16'h0000);
      close_out;
   end
endmodule // gated_16bit_timer_counter_tb
bind gtc_timer gtc_timer_sva chk (.*);
`default_nettype wire
